// ===== bcc_regs.svh
`ifndef BCC_REGS_SVH
`define BCC_REGS_SVH
// Register word addresses
`define BCC_ADDR_CFG 3'h0
`define BCC_ADDR_TIME_WIN 3'h1
`define BCC_ADDR_ALM_SETUP 3'h2
`define BCC_ADDR_ALM_WIN 3'h3
`define BCC_ADDR_KEY 3'h4
`define BCC_ADDR_PIN_SEL 3'h5
// Configuration field positions
`define BCC_CFG_EN 15
`define BCC_CFG_UNLOCK 13
`define BCC_CFG_OE 10
`define BCC_PTR_HI 9
`define BCC_PTR_LO 8
`define BCC_PIN_SEL_BIT 1
// Alarm setup field positions
`define BCC_ALM_ON 15
`define BCC_ALM_CHIME 14
`define BCC_IVL_HI 13
`define BCC_IVL_LO 10
// Unlock key values
`define BCC_KEY_FIRST 8'h55
`define BCC_KEY_SECOND 8'hAA
// Prescaler geometry in crystal pulses
`define BCC_PRE_BASE 512
`define BCC_RIPPLE_GUARD 32
// Alarm interval codes
`define BCC_IVL_HALF 4'h0
`define BCC_IVL_SEC 4'h1
`define BCC_IVL_10SEC 4'h2
`define BCC_IVL_MIN 4'h3
`define BCC_IVL_10MIN 4'h4
`define BCC_IVL_HOUR 4'h5
`define BCC_IVL_DAY 4'h6
`define BCC_IVL_WEEK 4'h7
`define BCC_IVL_MONTH 4'h8
`define BCC_IVL_YEAR 4'h9
// Calendar limits and reset values
`define BCC_SEC_MAX 7'h59
`define BCC_HOUR_MAX 6'h23
`define BCC_WDAY_MAX 3'h6
`define BCC_MONTH_MAX 5'h12
`define BCC_YEAR_MAX 8'h99
`define BCC_FIRST_DAY 6'h01
`define BCC_FIRST_MONTH 5'h01
`define BCC_RST_WDAY 3'h6
`define BCC_MON_FEB 5'h02
`endif

// ===== bcc_pkg.sv
`default_nettype none
package bcc_pkg;
	typedef struct packed {
		logic [7:0] year;
		logic [4:0] month;
		logic [5:0] day;
		logic [2:0] wday;
		logic [5:0] hour;
		logic [6:0] min;
		logic [6:0] sec;
	} bcc_time_s;
	typedef struct packed {
		logic [4:0] month;
		logic [5:0] day;
		logic [2:0] wday;
		logic [5:0] hour;
		logic [6:0] min;
		logic [6:0] sec;
	} bcc_alarm_s;
	typedef struct packed {
		logic calendar_enable;
		logic value_write_unlock;
		logic clock_output_enable;
		logic [1:0] time_window_pointer;
		logic [7:0] cal;
	} bcc_cfg_s;
	typedef struct packed {
		logic alarm_on;
		logic chime;
		logic [3:0] alarm_interval_select;
		logic [1:0] alarm_window_pointer;
		logic [7:0] alarm_repeat_count;
	} bcc_alm_setup_s;
	typedef enum logic [1:0] {BCC_KEY_IDLE, BCC_KEY_ARMED, BCC_KEY_OPEN} bcc_key_e;
	typedef struct packed {
		logic [2:0] addr;
		logic [15:0] wdata;
		logic [1:0] lanes;
		logic wr;
		logic rd;
	} bcc_bus_req_s;
	typedef struct packed {
		bcc_cfg_s cfg;
		bcc_time_s tm;
		bcc_alm_setup_s alm_setup;
		bcc_alarm_s alm;
		bcc_key_e key;
		logic [3:0] key_cnt;
		logic sec_sel;
		logic [16:0] pre;
		logic xtal_prev;
		logic pulse;
		logic pin;
		logic [15:0] rdata;
	} bcc_state_s;
endpackage
`default_nettype wire

// ===== bcc_calendar_clock.sv
// Decided for this implementation: the plain strobed port and the placing of the registers.
`include "bcc_regs.svh"
`default_nettype none
// Summary of operation
// [RL1] Calendar runs from 2000-01-01 00:00:00 to 2099-12-31 23:59:59 with leap days.
// [RL2] Hours count 00 to 23 only, no AM/PM.
// [RL3] Time steps once a second; a status bit shows the second half.
// [RL4] Timekeeping comes from a 32.768 kHz crystal, not the processor clock.
// [RL5] All time, date and alarm fields are held as BCD digits.
// [RL6] Configuration bits 9:8 point the time window at a register pair.
// [RL7] Pointer 00 min/sec, 01 weekday/hours, 10 month/day, 11 blank/year.
// [RL8] Writing the time window high byte steps the pointer down, stopping at 00.
// [RL9] Reading either window byte steps its pointer down; writes only on high byte.
// [RL10] Alarm setup bits 9:8 point the alarm window; 11 is unimplemented.
// [RL11] Writing the alarm window high byte steps its pointer down, stopping at 00.
// [RL12] Time window writes are ignored unless the unlock bit is set.
// [RL13] Unlock bit may be set only right after key writes 55h then AAh.
// [RL14] Software keeps the unlock bit clear except while updating the time.
// [RL15] The enable bit changes only while the unlock bit is already set.
// [RL16] Read-only ripple flag is set while a rollover may be under way.
// [RL17] Half-second bit is read-only and clears on a min/sec low-byte write.
// [RL18] With output enable set, pin carries alarm pulse or seconds clock.
// [RL19] Bits 7:0 hold an eight-bit drift calibration value.
// [RL20] Configuration register is reset only by power-on reset.
// [RL21] Calibration acts once a minute in steps of four crystal pulses.
// [RL22] Alarm interval codes 0000 to 1001 select half-second to yearly.
// [RL23] Repeat count falls on each alarm, stopping at zero unless chime wraps it.
// [RL24] Each second tick cascades BCD rollovers through the whole calendar.
// [RL25] Crystal and bus activity are brought safely into one clock domain; the crystal is taken as synchronous here, with no synchronizer.
module bcc_calendar_clock #(
	parameter int XTAL_HZ = 32768,
	parameter int KEY_WIN_CYC = 1
) (
	// Clock and resets
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic por_rstn_in,
	// Crystal timebase
	input wire logic xtal_in,
	// Register port
	input wire bcc_pkg::bcc_bus_req_s bus_in,
	output logic [15:0] rdata_out,
	// Calendar output pin
	output logic calendar_out
);
	localparam logic [16:0] PRE_BASE = 17'(`BCC_PRE_BASE);
	localparam logic [16:0] PRE_TOP = 17'(`BCC_PRE_BASE + XTAL_HZ - 1);
	localparam logic [16:0] PRE_HALF = 17'(`BCC_PRE_BASE + XTAL_HZ / 2);
	localparam logic [16:0] PRE_RIPPLE = 17'(`BCC_PRE_BASE + XTAL_HZ - `BCC_RIPPLE_GUARD);
	localparam logic [3:0] KEY_WIN = 4'(KEY_WIN_CYC);

	// Refuse geometries the prescaler and key counter cannot hold
	generate
		if (XTAL_HZ < 1024 || XTAL_HZ > 65536 || KEY_WIN_CYC < 1 || KEY_WIN_CYC > 15) begin : g_chk
			$error("bcc_calendar_clock: parameter out of range");
		end
	endgenerate

	bcc_pkg::bcc_state_s st_reg;
	bcc_pkg::bcc_state_s st_next;
	logic tick_w;
	logic half_w;
	logic evt_w;
	logic xedge_w;

	// Leap year within 2000..2099: every fourth year
	function automatic logic is_leap(input logic [7:0] y);
		is_leap = (!y[4] && (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8)) ||
			(y[4] && (y[3:0] == 4'h2 || y[3:0] == 4'h6));
	endfunction

	// Last BCD day of a month
	function automatic logic [5:0] last_day(input logic [4:0] m, input logic [7:0] y);
		if (m == `BCC_MON_FEB) begin
			last_day = is_leap(y) ? 6'h29 : 6'h28;
		end else if (m == 5'h04 || m == 5'h06 || m == 5'h09 || m == 5'h11) begin
			last_day = 6'h30;
		end else begin
			last_day = 6'h31;
		end
	endfunction

	// Two-digit BCD increment
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
	endfunction

	// Saturating pointer step down
	function automatic logic [1:0] ptr_dec(input logic [1:0] p);
		ptr_dec = (p == 2'b00) ? 2'b00 : p - 2'b01;
	endfunction

	// One-second cascade through the calendar
	function automatic bcc_pkg::bcc_time_s advance(input bcc_pkg::bcc_time_s t);
		bcc_pkg::bcc_time_s r;
		r = t;
		if (t.sec != `BCC_SEC_MAX) begin
			r.sec = 7'(bcd_inc({1'b0, t.sec}));
		end else begin
			r.sec = 7'h00;
			if (t.min != `BCC_SEC_MAX) begin
				r.min = 7'(bcd_inc({1'b0, t.min}));
			end else begin
				r.min = 7'h00;
				if (t.hour != `BCC_HOUR_MAX) begin
					r.hour = 6'(bcd_inc({2'b00, t.hour}));
				end else begin
					r.hour = 6'h00;
					r.wday = (t.wday == `BCC_WDAY_MAX) ? 3'h0 : t.wday + 3'h1;
					if (t.day != last_day(t.month, t.year)) begin
						r.day = 6'(bcd_inc({2'b00, t.day}));
					end else begin
						r.day = `BCC_FIRST_DAY;
						if (t.month != `BCC_MONTH_MAX) begin
							r.month = 5'(bcd_inc({3'b000, t.month}));
						end else begin
							r.month = `BCC_FIRST_MONTH;
							r.year = (t.year == `BCC_YEAR_MAX) ? 8'h00 : bcd_inc(t.year);
						end
					end
				end
			end
		end
		advance = r;
	endfunction

	// Alarm comparison per interval code
	function automatic logic alarm_match(input logic [3:0] ivl, input bcc_pkg::bcc_time_s t,
		input bcc_pkg::bcc_alarm_s a);
		logic s_eq;
		logic m_eq;
		s_eq = (t.sec == a.sec);
		m_eq = s_eq && (t.min == a.min);
		unique case (ivl)
			`BCC_IVL_HALF, `BCC_IVL_SEC: alarm_match = 1'b1;
			`BCC_IVL_10SEC: alarm_match = (t.sec[3:0] == a.sec[3:0]);
			`BCC_IVL_MIN: alarm_match = s_eq;
			`BCC_IVL_10MIN: alarm_match = s_eq && (t.min[3:0] == a.min[3:0]);
			`BCC_IVL_HOUR: alarm_match = m_eq;
			`BCC_IVL_DAY: alarm_match = m_eq && (t.hour == a.hour);
			`BCC_IVL_WEEK: alarm_match = m_eq && (t.hour == a.hour) && (t.wday == a.wday);
			`BCC_IVL_MONTH: alarm_match = m_eq && (t.hour == a.hour) && (t.day == a.day);
			`BCC_IVL_YEAR: alarm_match = m_eq && (t.hour == a.hour) && (t.day == a.day) &&
				(t.month == a.month);
			default: alarm_match = 1'b0;
		endcase
	endfunction

	// Next-state logic for the whole block
	always_comb begin
		st_next = st_reg;
		st_next.rdata = 16'h0000;
		tick_w = 1'b0;
		half_w = 1'b0;
		// Crystal taken as synchronous; one flop finds its rising edge
		st_next.xtal_prev = xtal_in; // [RL25] [RL4]
		xedge_w = xtal_in && !st_reg.xtal_prev;
		if (st_reg.cfg.calendar_enable && xedge_w) begin
			if (st_reg.pre >= PRE_TOP) begin
				tick_w = 1'b1; // [RL3]
				// Minute boundary restarts the prescaler shifted by calibration
				if (st_reg.tm.sec == `BCC_SEC_MAX) begin
					st_next.pre = PRE_BASE + {{7{st_reg.cfg.cal[7]}}, st_reg.cfg.cal, 2'b00}; // [RL21]
				end else begin
					st_next.pre = PRE_BASE;
				end
			end else begin
				st_next.pre = st_reg.pre + 17'h0_0001;
				half_w = (st_reg.pre + 17'h0_0001 == PRE_HALF);
			end
		end
		if (tick_w) begin
			st_next.tm = advance(st_reg.tm); // [RL24] [RL1] [RL2]
		end
		// Alarm events, counted down or wrapped by chime
		evt_w = st_reg.alm_setup.alarm_on &&
			((tick_w && alarm_match(st_reg.alm_setup.alarm_interval_select, st_next.tm,
			st_reg.alm)) ||
			(half_w && st_reg.alm_setup.alarm_interval_select == `BCC_IVL_HALF)); // [RL22]
		if (evt_w) begin
			st_next.pulse = 1'b1;
			if (st_reg.alm_setup.alarm_repeat_count != 8'h00) begin
				st_next.alm_setup.alarm_repeat_count = st_reg.alm_setup.alarm_repeat_count - 8'h01;
			end else if (st_reg.alm_setup.chime) begin
				st_next.alm_setup.alarm_repeat_count = 8'hFF; // [RL23]
			end else begin
				st_next.alm_setup.alarm_on = 1'b0; // [RL23]
			end
		end else if (tick_w || half_w) begin
			st_next.pulse = 1'b0;
		end
		// Key window ages out after its last cycle
		if (st_reg.key == bcc_pkg::BCC_KEY_OPEN) begin
			if (st_reg.key_cnt <= 4'h1) begin
				st_next.key = bcc_pkg::BCC_KEY_IDLE;
			end else begin
				st_next.key_cnt = st_reg.key_cnt - 4'h1;
			end
		end
		// Register writes, after the timebase so software wins
		if (bus_in.wr) begin
			if (st_reg.key == bcc_pkg::BCC_KEY_ARMED && bus_in.addr != `BCC_ADDR_KEY) begin
				st_next.key = bcc_pkg::BCC_KEY_IDLE;
			end
			unique case (bus_in.addr)
				`BCC_ADDR_CFG: begin
					if (bus_in.lanes[0]) begin
						st_next.cfg.cal = bus_in.wdata[7:0]; // [RL19]
					end
					if (bus_in.lanes[1]) begin
						st_next.cfg.clock_output_enable = bus_in.wdata[`BCC_CFG_OE];
						st_next.cfg.time_window_pointer = bus_in.wdata[`BCC_PTR_HI:`BCC_PTR_LO]; // [RL6]
						if (!bus_in.wdata[`BCC_CFG_UNLOCK]) begin
							st_next.cfg.value_write_unlock = 1'b0;
						end else if (st_reg.key == bcc_pkg::BCC_KEY_OPEN) begin
							st_next.cfg.value_write_unlock = 1'b1; // [RL13]
						end
						if (st_reg.cfg.value_write_unlock) begin
							st_next.cfg.calendar_enable = bus_in.wdata[`BCC_CFG_EN]; // [RL15]
						end
						st_next.key = bcc_pkg::BCC_KEY_IDLE;
					end
				end
				`BCC_ADDR_TIME_WIN: begin
					if (st_reg.cfg.value_write_unlock) begin // [RL12]
						unique case (st_reg.cfg.time_window_pointer) // [RL7]
							2'b00: begin
								if (bus_in.lanes[1]) st_next.tm.min = bus_in.wdata[14:8];
								if (bus_in.lanes[0]) begin
									st_next.tm.sec = bus_in.wdata[6:0];
									st_next.pre = PRE_BASE; // [RL17]
								end
							end
							2'b01: begin
								if (bus_in.lanes[1]) st_next.tm.wday = bus_in.wdata[10:8];
								if (bus_in.lanes[0]) st_next.tm.hour = bus_in.wdata[5:0];
							end
							2'b10: begin
								if (bus_in.lanes[1]) st_next.tm.month = bus_in.wdata[12:8];
								if (bus_in.lanes[0]) st_next.tm.day = bus_in.wdata[5:0];
							end
							2'b11: begin
								if (bus_in.lanes[0]) st_next.tm.year = bus_in.wdata[7:0];
							end
						endcase
						if (bus_in.lanes[1]) begin
							st_next.cfg.time_window_pointer = ptr_dec(st_reg.cfg.time_window_pointer); // [RL8]
						end
					end
				end
				`BCC_ADDR_ALM_SETUP: begin
					if (bus_in.lanes[0]) begin
						st_next.alm_setup.alarm_repeat_count = bus_in.wdata[7:0];
					end
					if (bus_in.lanes[1]) begin
						st_next.alm_setup.alarm_on = bus_in.wdata[`BCC_ALM_ON];
						st_next.alm_setup.chime = bus_in.wdata[`BCC_ALM_CHIME];
						st_next.alm_setup.alarm_interval_select = bus_in.wdata[`BCC_IVL_HI:`BCC_IVL_LO];
						st_next.alm_setup.alarm_window_pointer = bus_in.wdata[`BCC_PTR_HI:`BCC_PTR_LO]; // [RL10]
					end
				end
				`BCC_ADDR_ALM_WIN: begin
					unique case (st_reg.alm_setup.alarm_window_pointer) // [RL10] [RL5]
						2'b00: begin
							if (bus_in.lanes[1]) st_next.alm.min = bus_in.wdata[14:8];
							if (bus_in.lanes[0]) st_next.alm.sec = bus_in.wdata[6:0];
						end
						2'b01: begin
							if (bus_in.lanes[1]) st_next.alm.wday = bus_in.wdata[10:8];
							if (bus_in.lanes[0]) st_next.alm.hour = bus_in.wdata[5:0];
						end
						2'b10: begin
							if (bus_in.lanes[1]) st_next.alm.month = bus_in.wdata[12:8];
							if (bus_in.lanes[0]) st_next.alm.day = bus_in.wdata[5:0];
						end
						2'b11: begin
						end
					endcase
					if (bus_in.lanes[1]) begin
						st_next.alm_setup.alarm_window_pointer =
							ptr_dec(st_reg.alm_setup.alarm_window_pointer); // [RL11]
					end
				end
				`BCC_ADDR_KEY: begin
					if (bus_in.lanes[0] && bus_in.wdata[7:0] == `BCC_KEY_FIRST) begin
						st_next.key = bcc_pkg::BCC_KEY_ARMED;
					end else if (bus_in.lanes[0] && bus_in.wdata[7:0] == `BCC_KEY_SECOND &&
						st_reg.key == bcc_pkg::BCC_KEY_ARMED) begin
						st_next.key = bcc_pkg::BCC_KEY_OPEN; // [RL13]
						st_next.key_cnt = KEY_WIN;
					end else begin
						st_next.key = bcc_pkg::BCC_KEY_IDLE;
					end
				end
				`BCC_ADDR_PIN_SEL: begin
					if (bus_in.lanes[0]) st_next.sec_sel = bus_in.wdata[`BCC_PIN_SEL_BIT];
				end
				default: begin
				end
			endcase
		end
		// Register reads, answered in the next cycle
		if (bus_in.rd) begin
			unique case (bus_in.addr)
				`BCC_ADDR_CFG: st_next.rdata = {st_reg.cfg.calendar_enable, 1'b0,
					st_reg.cfg.value_write_unlock,
					st_reg.cfg.calendar_enable && st_reg.pre >= PRE_RIPPLE, // [RL16]
					st_reg.pre >= PRE_HALF, // [RL3] [RL17]
					st_reg.cfg.clock_output_enable, st_reg.cfg.time_window_pointer,
					st_reg.cfg.cal};
				`BCC_ADDR_TIME_WIN: begin
					unique case (st_reg.cfg.time_window_pointer) // [RL7]
						2'b00: st_next.rdata = {1'b0, st_reg.tm.min, 1'b0, st_reg.tm.sec};
						2'b01: st_next.rdata = {5'h00, st_reg.tm.wday, 2'b00, st_reg.tm.hour};
						2'b10: st_next.rdata = {3'h0, st_reg.tm.month, 2'b00, st_reg.tm.day};
						2'b11: st_next.rdata = {8'h00, st_reg.tm.year};
					endcase
					st_next.cfg.time_window_pointer = ptr_dec(st_reg.cfg.time_window_pointer); // [RL9]
				end
				`BCC_ADDR_ALM_SETUP: st_next.rdata = st_reg.alm_setup;
				`BCC_ADDR_ALM_WIN: begin
					unique case (st_reg.alm_setup.alarm_window_pointer)
						2'b00: st_next.rdata = {1'b0, st_reg.alm.min, 1'b0, st_reg.alm.sec};
						2'b01: st_next.rdata = {5'h00, st_reg.alm.wday, 2'b00, st_reg.alm.hour};
						2'b10: st_next.rdata = {3'h0, st_reg.alm.month, 2'b00, st_reg.alm.day};
						2'b11: st_next.rdata = 16'h0000;
					endcase
					st_next.alm_setup.alarm_window_pointer =
						ptr_dec(st_reg.alm_setup.alarm_window_pointer); // [RL9]
				end
				`BCC_ADDR_PIN_SEL: st_next.rdata = {14'h0000, st_reg.sec_sel, 1'b0};
				default: st_next.rdata = 16'h0000;
			endcase
		end
		// Output pin: seconds clock or stretched alarm pulse
		st_next.pin = st_reg.cfg.clock_output_enable &&
			(st_reg.sec_sel ? (st_next.pre < PRE_HALF) : st_next.pulse); // [RL18]
		// Resets: the configuration survives all but power-on
		if (!rstn_in || !por_rstn_in) begin
			st_next = '0;
			st_next.cfg = st_reg.cfg; // [RL20]
			st_next.cfg.time_window_pointer = st_reg.cfg.time_window_pointer;
			st_next.key = bcc_pkg::BCC_KEY_IDLE;
			st_next.pre = PRE_BASE;
			st_next.xtal_prev = 1'b1;
			st_next.tm.day = `BCC_FIRST_DAY; // [RL1]
			st_next.tm.month = `BCC_FIRST_MONTH;
			st_next.tm.wday = `BCC_RST_WDAY;
			st_next.alm.day = `BCC_FIRST_DAY;
			st_next.alm.month = `BCC_FIRST_MONTH;
			if (!por_rstn_in) begin
				st_next.cfg = '0; // [RL20]
			end
		end
	end

	// State register
	always_ff @(posedge mclk_in) begin
		st_reg <= st_next;
	end

	// Outputs straight from the state register
	assign rdata_out = st_reg.rdata;
	assign calendar_out = st_reg.pin;

	// Checks on the block's own behaviour
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rstn_in || !por_rstn_in);

	a_time_lock_holds: assert property ((bus_in.wr && bus_in.addr == `BCC_ADDR_TIME_WIN && // [RL12]
		!st_reg.cfg.value_write_unlock && !tick_w) |=> (st_reg.tm == $past(st_reg.tm)))
		else $error("locked time write changed the time");
	a_time_ptr_floor: assert property ((bus_in.wr && bus_in.lanes[1] && // [RL8]
		bus_in.addr == `BCC_ADDR_TIME_WIN && st_reg.cfg.value_write_unlock &&
		st_reg.cfg.time_window_pointer == 2'b00) |=> (st_reg.cfg.time_window_pointer == 2'b00))
		else $error("time pointer left zero on write");
	a_read_ptr_step: assert property ((bus_in.rd && bus_in.addr == `BCC_ADDR_ALM_WIN && // [RL9]
		st_reg.alm_setup.alarm_window_pointer != 2'b00 && !bus_in.wr) |=>
		(st_reg.alm_setup.alarm_window_pointer == $past(st_reg.alm_setup.alarm_window_pointer) - 2'b01))
		else $error("alarm pointer did not step on read");
	a_enable_guarded: assert property ((bus_in.wr && bus_in.addr == `BCC_ADDR_CFG && // [RL15]
		!st_reg.cfg.value_write_unlock) |=> $stable(st_reg.cfg.calendar_enable))
		else $error("enable changed while locked");
	a_unlock_by_key: assert property ($rose(st_reg.cfg.value_write_unlock) |-> // [RL13]
		($past(st_reg.key) == bcc_pkg::BCC_KEY_OPEN))
		else $error("unlock set without key window");
	a_half_cleared: assert property ((bus_in.wr && bus_in.lanes[0] && // [RL17]
		bus_in.addr == `BCC_ADDR_TIME_WIN && st_reg.cfg.value_write_unlock &&
		st_reg.cfg.time_window_pointer == 2'b00) |=>
		(st_reg.pre == PRE_BASE))
		else $error("half second not cleared by seconds write");
	a_bcd_digits: assert property ((st_reg.tm.sec[3:0] <= 4'h9) && (st_reg.tm.sec <= `BCC_SEC_MAX) && // [RL5]
		(st_reg.tm.min[3:0] <= 4'h9) && (st_reg.tm.hour <= `BCC_HOUR_MAX)) // [RL2]
		else $error("time field outside BCD range");
	a_second_wrap: assert property ((tick_w && st_reg.tm.sec == `BCC_SEC_MAX && // [RL24]
		!bus_in.wr) |=> (st_reg.tm.sec == 7'h00 && st_reg.tm.min != $past(st_reg.tm.min)))
		else $error("seconds did not carry into minutes");
	a_repeat_stops: assert property ((evt_w && !st_reg.alm_setup.chime && !bus_in.wr && // [RL23]
		st_reg.alm_setup.alarm_repeat_count == 8'h00) |=> !st_reg.alm_setup.alarm_on)
		else $error("alarm not disabled at zero repeats");
	a_pin_quiet: assert property (!st_reg.cfg.clock_output_enable |=> !calendar_out) // [RL18]
		else $error("pin driven while output disabled");
endmodule
`default_nettype wire

// ===== bcc_dummy_end.sv
`default_nettype none
`default_nettype wire

// ===== bcd_calendar_clock_window_tb_top.sv
`default_nettype none
module bcd_calendar_clock_window_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic por_rstn_in = 1'b0;
	logic xtal_in = 1'b0;
	bcc_pkg::bcc_bus_req_s bus_in = '0;
	logic [15:0] rdata_out;
	logic calendar_out;
	logic [1:0] xdiv = 2'h0;
	logic [15:0] v;
	logic [7:0] c;
	int error_cnt = 0;
	int samples_checked = 0;
	int pin_hi;
	int pin_lo;
	logic pin_seen;

	// Short second keeps each rollover near 8192 clocks
	bcc_calendar_clock #(.XTAL_HZ(1024), .KEY_WIN_CYC(1)) i_bcc_calendar_clock (
		.mclk_in(mclk_in),
		.rstn_in(rstn_in),
		.por_rstn_in(por_rstn_in),
		.xtal_in(xtal_in),
		.bus_in(bus_in),
		.rdata_out(rdata_out),
		.calendar_out(calendar_out)
	);

	// Clock of 40 ns
	always #20 mclk_in = ~mclk_in;

	// Crystal stand-in, one rising edge every eight clocks
	always @(posedge mclk_in) begin
		xdiv <= xdiv + 2'h1;
		if (xdiv == 2'h3) xtal_in <= ~xtal_in;
	end

	// Reference helpers for calendar arithmetic
	function automatic logic [7:0] bcd(input int n);
		return 8'((n / 10) * 16 + n % 10);
	endfunction
	function automatic int mdays(input int y, input int m);
		if (m == 2) return (y % 4 == 0) ? 29 : 28;
		if (m == 4 || m == 6 || m == 9 || m == 11) return 30;
		return 31;
	endfunction

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Bus cycles, each launched just after a rising edge
	task automatic drive(input logic [2:0] a, input logic [15:0] d, input logic [1:0] l,
		input logic w, input logic r);
		bus_in <= '{addr: a, wdata: d, lanes: l, wr: w, rd: r};
		@(posedge mclk_in);
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d, input logic [1:0] l = 2'b11);
		drive(a, d, l, 1'b1, 1'b0);
		drive(3'h0, 16'h0000, 2'b00, 1'b0, 1'b0);
	endtask
	task automatic rd(input logic [2:0] a, output logic [15:0] q);
		drive(a, 16'h0000, 2'b00, 1'b0, 1'b1);
		bus_in <= '0;
		#1 q = rdata_out;
		pin_seen = calendar_out;
		@(posedge mclk_in);
	endtask
	task automatic rdc(input logic [2:0] a, input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
		rd(a, v);
		chk(v & m, e & m);
	endtask
	// Key pair then a config high-byte write in the very next cycle
	task automatic key(input logic [15:0] cfg);
		drive(3'h4, 16'h0055, 2'b11, 1'b1, 1'b0);
		drive(3'h4, 16'h00AA, 2'b11, 1'b1, 1'b0);
		drive(3'h0, cfg, 2'b10, 1'b1, 1'b0);
		drive(3'h0, 16'h0000, 2'b00, 1'b0, 1'b0);
	endtask

	// Set one second before midnight, wait the tick, read the new date
	task automatic roll(input int y, input int m, input int d, input int wd);
		int nd;
		int nm;
		int ny;
		nd = d + 1;
		nm = m;
		ny = y;
		if (nd > mdays(y, m)) begin
			nd = 1;
			nm = m + 1;
		end
		if (nm > 12) begin
			nm = 1;
			ny = (y + 1) % 100;
		end
		key(16'hA700);
		wr(3'h1, {8'h00, bcd(y)});
		wr(3'h1, {bcd(m), bcd(d)});
		wr(3'h1, {5'h00, 3'(wd), 8'h23});
		wr(3'h1, 16'h5959);
		rdc(3'h0, 16'hA400, 16'hFF00); // Pointer at 00, half clear
		pin_hi = 0;
		pin_lo = 0;
		v = 16'h5959;
		for (int i = 0; i < 6000 && v !== 16'h0000; i++) begin
			rd(3'h1, v);
			if (pin_seen === 1'b1) pin_hi++;
			else pin_lo++;
		end
		chk(v, 16'h0000); // Seconds tick arrived
		if (v !== 16'h0000) report_and_stop();
		chk(16'(pin_hi > 0 && pin_lo > 0), 16'h0001); // Seconds clock on pin
		key(16'hA700);
		rdc(3'h1, {8'h00, bcd(ny)}); // Year in BCD
		rdc(3'h1, {bcd(nm), bcd(nd)}); // Month and day
		rdc(3'h1, {5'h00, 3'((wd + 1) % 7), 8'h00}); // Hours wrap at 24
	endtask

	// Main sequence
	initial begin
		void'($urandom(68));
		repeat (10) @(posedge mclk_in);
		rstn_in <= 1'b1;
		por_rstn_in <= 1'b1;
		@(posedge mclk_in);
		rdc(3'h0, 16'h0000); // Config cleared by power-on
		chk({15'h0000, pin_seen}, 16'h0000); // Pin idle when disabled
		rdc(3'h7, 16'h0000);
		wr(3'h1, 16'h1234);
		rdc(3'h1, 16'h0000); // Locked write dropped
		wr(3'h0, 16'h8400, 2'b10);
		rdc(3'h0, 16'h0400); // Enable kept while locked
		drive(3'h4, 16'h0055, 2'b11, 1'b1, 1'b0);
		drive(3'h4, 16'h00AA, 2'b11, 1'b1, 1'b0);
		drive(3'h0, 16'h0000, 2'b00, 1'b0, 1'b0);
		wr(3'h0, 16'h2000, 2'b10);
		rdc(3'h0, 16'h0000, 16'h2000); // Late unlock refused
		// Alarm window walk, including the unimplemented slot
		wr(3'h2, 16'h0200);
		wr(3'h3, 16'h0315);
		wr(3'h3, 16'h0410);
		wr(3'h3, 16'h3045);
		rdc(3'h2, 16'h0000); // Alarm pointer down to 00
		wr(3'h2, 16'h0300);
		wr(3'h3, 16'hFFFF);
		rdc(3'h3, 16'h0315); // Month and day slot
		rdc(3'h3, 16'h0410); // Weekday and hours slot
		rdc(3'h3, 16'h3045); // Minutes and seconds slot
		rdc(3'h3, 16'h3045); // Pointer holds at 00
		// Rollovers across year end, leap day and plain February
		wr(3'h5, 16'h0002);
		key(16'h2400);
		roll(99, 12, 31, 2);
		roll(24, 2, 28, 6);
		roll(23, 2, 28, 1);
		// Half-second alarm, two repeats, then it switches itself off
		wr(3'h0, 16'h8400, 2'b10); // Lock again once the time is set
		wr(3'h5, 16'h0000);
		wr(3'h2, 16'h8002);
		pin_hi = 0;
		v = 16'h8002;
		for (int i = 0; i < 12000 && v !== 16'h0000; i++) begin
			rd(3'h2, v);
			if (pin_seen === 1'b1) pin_hi++;
		end
		chk(v, 16'h0000); // Three events, repeats spent, alarm off
		if (v !== 16'h0000) report_and_stop();
		chk(16'(pin_hi > 0), 16'h0001); // Alarm pulse reaches the pin
		c = 8'($urandom);
		wr(3'h0, {8'h00, c}, 2'b01);
		rdc(3'h0, {8'h84, c}, 16'hE7FF); // Calibration byte
		rstn_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
		rstn_in <= 1'b1;
		@(posedge mclk_in);
		rdc(3'h0, {8'h84, c}, 16'hE7FF); // Config survives plain reset
		rdc(3'h1, 16'h0000); // Time restarts at midnight
		report_and_stop();
	end
endmodule
`default_nettype wire
